// >>> design/dms_sequencer.sv
// drive mode sequencer: command decode, status word, block control
//
// Notes on behaviour
// (RULE1) mode selector value 9 selects cyclic synchronous velocity mode.
// (RULE2) each reference speed written in velocity mode becomes the target.
// (RULE3) cyclic modes use only the command low nibble for control.
// (RULE4) velocity status bit 12 shows following, bit 13 following error.
// (RULE5) controller limits acceleration itself; no ramp inside device.
// (RULE6) controller writes 0x00,0x06,0x07,0x0F then waits for bit 12.
// (RULE7) status answers 0x0050, 0x0031, 0x0033, low byte 0x37.
// (RULE8) enable to 0x0007 stops cyclic mode; enable again restarts.
// (RULE9) mode change is safe under 0x0007; new mode needs its sequence.
// (RULE10) controller checks status low byte 0x33 before changing mode.
// (RULE11) mode selector 0xFF selects table travel record mode.
// (RULE12) targets come from stored motion blocks; many blocks supported.
// (RULE13) halt clear: bit 4 picks single block or automatic sequence.
// (RULE14) halt bit 8 stops axis with block ramp; stays enabled.
// (RULE15) rising bit 9 starts blocks; bit 9 low stops the axis.
// (RULE16) bit 6 clear uses select field; set resumes last active block.
// (RULE17) select field n in bits 15..11 starts block n plus one.
// (RULE18) status bit 8 is high while a block or sequence runs.
// (RULE19) target reached sets when position enters the window.
// (RULE20) start edge found against command registered last cycle.
// (RULE21) without enable, mode bits are ignored and nothing starts.
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "dms_consts.svh"
module dms_sequencer
  import dms_pkg::*;
#(
  parameter int VEL_W = 32
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  // axi4-lite write address and data
  input  wire logic [11:0]      awaddr_in,
  input  wire logic             awvalid_in,
  output logic                  awready_out,
  input  wire logic [31:0]      wdata_in,
  input  wire logic [3:0]       wstrb_in,
  input  wire logic             wvalid_in,
  output logic                  wready_out,
  // axi4-lite write response
  output logic [1:0]            bresp_out,
  output logic                  bvalid_out,
  input  wire logic             bready_in,
  // axi4-lite read
  input  wire logic [11:0]      araddr_in,
  input  wire logic             arvalid_in,
  output logic                  arready_out,
  output logic [31:0]           rdata_out,
  output logic [1:0]            rresp_out,
  output logic                  rvalid_out,
  input  wire logic             rready_in,
  // drive feedback pins
  input  wire logic [4:0]       drive_fb_in,
  // motion control outputs
  output logic [VEL_W-1:0]      vel_target_out,
  output logic                  vel_run_out,
  output logic                  blk_run_out,
  output logic                  blk_stop_out,
  output logic                  blk_auto_out,
  output logic [5:0]            blk_num_out
);

  dms_reg_if regs ();

  logic [15:0]      cmd;
  logic [15:0]      cmd_prev;
  logic [7:0]       mode;
  logic [VEL_W-1:0] vtgt_reg;
  logic [15:0]      status;
  logic [5:0]       active_blk;
  logic             resume_ok;
  logic [4:0]       fb;
  dms_dev_t         dev;
  dms_dev_t         next_dev;
  dms_run_t         run;
  dms_run_t         next_run;
  logic             mode_csv;
  logic             mode_ttr;
  logic             start_edge;
  logic [5:0]       start_blk;
  logic             was_enop;

  // ------------------------------
  // helper functions
  // ------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_enop(input logic [15:0] c);
    return c[3:0] == `DMS_NIB_ENOP;
  endfunction

  // ------------------------------
  // bus front end and feedback synchroniser
  // ------------------------------
  dms_axil_slave u_slave (
    .mclk_in     (mclk_in),
    .nrst_in     (nrst_in),
    .awaddr_in   (awaddr_in),
    .awvalid_in  (awvalid_in),
    .awready_out (awready_out),
    .wdata_in    (wdata_in),
    .wstrb_in    (wstrb_in),
    .wvalid_in   (wvalid_in),
    .wready_out  (wready_out),
    .bresp_out   (bresp_out),
    .bvalid_out  (bvalid_out),
    .bready_in   (bready_in),
    .araddr_in   (araddr_in),
    .arvalid_in  (arvalid_in),
    .arready_out (arready_out),
    .rdata_out   (rdata_out),
    .rresp_out   (rresp_out),
    .rvalid_out  (rvalid_out),
    .rready_in   (rready_in),
    .regs        (regs.slave)
  );

  dms_edge_sync #(.WIDTH(5)) u_fb_sync (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .async_in (drive_fb_in),
    .sync_out (fb)
  );

  // ------------------------------
  // register writes
  // ------------------------------

  always_comb begin
    unique case (regs.wr_addr)
      `DMS_OFF_CMD, `DMS_OFF_MODE, `DMS_OFF_VTGT: regs.wr_ok = 1'b1;
      `DMS_OFF_STAT, `DMS_OFF_VACT, `DMS_OFF_BLOCK,
      `DMS_OFF_DRVSTAT: regs.wr_ok = 1'b1;
      default: regs.wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd  <= `DMS_RST_CMD;
      mode <= `DMS_RST_MODE;
    end else if (regs.wr_stb) begin
      if (regs.wr_addr == `DMS_OFF_CMD) begin
        cmd <= 16'(merge_bytes({16'h0000, cmd}, regs.wr_data,
                               regs.wr_strb));
      end
      if (regs.wr_addr == `DMS_OFF_MODE) begin
        mode <= 8'(merge_bytes({24'h000000, mode}, regs.wr_data,
                               regs.wr_strb));
      end
    end
  end

  // each written reference speed is taken as the velocity target
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vtgt_reg <= `DMS_RST_VTGT;
    end else if (regs.wr_stb && regs.wr_addr == `DMS_OFF_VTGT) begin
      vtgt_reg <= VEL_W'(merge_bytes(32'(vtgt_reg), regs.wr_data,
                                     regs.wr_strb)); // [RULE2]
    end
  end

  // ------------------------------
  // register reads
  // ------------------------------
  always_comb begin
    regs.rd_ok   = 1'b1;
    regs.rd_data = 32'h0000_0000;
    unique case (regs.rd_addr)
      `DMS_OFF_CMD:     regs.rd_data = {16'h0000, cmd};
      `DMS_OFF_STAT:    regs.rd_data = {16'h0000, status};
      `DMS_OFF_MODE:    regs.rd_data = {24'h000000, mode};
      `DMS_OFF_VTGT:    regs.rd_data = 32'(vtgt_reg);
      `DMS_OFF_VACT:    regs.rd_data = {31'h0, vel_run_out};
      `DMS_OFF_BLOCK:   regs.rd_data = {25'h0, resume_ok, active_blk}; // [RULE16]
      `DMS_OFF_DRVSTAT: regs.rd_data = {27'h0, fb};
      default:          regs.rd_ok   = 1'b0;
    endcase
  end

  // ------------------------------
  // device state from command low nibble
  // ------------------------------
  assign mode_csv = (mode == `DMS_MODE_CSV); // [RULE1]
  assign mode_ttr = (mode == `DMS_MODE_TTR); // [RULE11]

  // only the low nibble drives device state in every mode [RULE3]
  always_comb begin
    unique case (cmd[3:0])
      `DMS_NIB_SHUT: next_dev = DMS_DEV_RDY;
      `DMS_NIB_SWON: next_dev = DMS_DEV_SWON;
      `DMS_NIB_ENOP: next_dev = DMS_DEV_ENOP;
      default:       next_dev = DMS_DEV_DIS;
    endcase
    if (next_dev == DMS_DEV_SWON && dev == DMS_DEV_DIS) begin
      next_dev = DMS_DEV_DIS;
    end
    if (next_dev == DMS_DEV_ENOP && dev != DMS_DEV_SWON
        && dev != DMS_DEV_ENOP) begin
      next_dev = dev;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dev <= DMS_DEV_DIS;
    end else begin
      dev <= next_dev;
    end
  end

  // ------------------------------
  // status word
  // ------------------------------
  always_comb begin
    unique case (dev)
      DMS_DEV_DIS:  status = `DMS_ST_DIS; // [RULE7]
      DMS_DEV_RDY:  status = `DMS_ST_RDY; // [RULE7]
      DMS_DEV_SWON: status = `DMS_ST_SWON; // [RULE7]
      DMS_DEV_ENOP: begin
        status = {8'h00, `DMS_ST_ENOP_LO}; // [RULE7]
        if (mode_csv) begin
          status[`DMS_ST_FOLLOW] = vel_run_out; // [RULE4]
          status[`DMS_ST_FERR]   = fb[`DMS_DS_FERR]; // [RULE4]
        end else if (mode_ttr) begin
          status[`DMS_ST_INPROG] = (run != DMS_RUN_IDLE); // [RULE18]
          status[`DMS_ST_TREACH] = cmd[`DMS_CMD_HALT] || !blk_run_out
                                   ? fb[`DMS_DS_SPEED0]
                                   : fb[`DMS_DS_IN_WIN]; // [RULE19]
          status[`DMS_ST_FERR]   = fb[`DMS_DS_FERR];
        end
      end
    endcase
  end

  // ------------------------------
  // cyclic velocity mode
  // ------------------------------
  // enable to switched-on stops, enable again restarts [RULE8]
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vel_run_out    <= 1'b0;
      vel_target_out <= '0;
    end else begin
      vel_run_out    <= mode_csv && dev == DMS_DEV_ENOP; // [RULE8] [RULE9]
      vel_target_out <= (mode_csv && dev == DMS_DEV_ENOP)
                        ? vtgt_reg : '0; // [RULE2] [RULE5]
    end
  end

  // ------------------------------
  // table travel record block control
  // ------------------------------
  assign was_enop   = (dev == DMS_DEV_ENOP) && is_enop(cmd);
  // edge against the previous cycle's command word [RULE20]
  assign start_edge = cmd[`DMS_CMD_START] && !cmd_prev[`DMS_CMD_START];
  assign start_blk  = (cmd[`DMS_CMD_RESUME] && resume_ok)
                      ? active_blk // [RULE16]
                      : {1'b0, cmd[`DMS_CMD_SEL_HI:`DMS_CMD_SEL_LO]}
                        + `DMS_BLK_FIRST; // [RULE17]

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_prev <= `DMS_RST_CMD;
    end else begin
      cmd_prev <= cmd; // [RULE20]
    end
  end

  always_comb begin
    next_run = run;
    if (!was_enop || !mode_ttr) begin
      next_run = DMS_RUN_IDLE; // [RULE21]
    end else begin
      unique case (run)
        DMS_RUN_IDLE: if (start_edge && !cmd[`DMS_CMD_HALT]) begin
          next_run = DMS_RUN_MOVE; // [RULE15] [RULE13]
        end
        DMS_RUN_MOVE: begin
          if (!cmd[`DMS_CMD_START] || cmd[`DMS_CMD_HALT]) begin
            next_run = DMS_RUN_STOP; // [RULE14] [RULE15]
          end else if (fb[`DMS_DS_BLK_DONE] && (!blk_auto_out
                       || fb[`DMS_DS_SEQ_END])) begin
            next_run = DMS_RUN_IDLE; // [RULE18]
          end
        end
        DMS_RUN_STOP: begin
          if (start_edge || (cmd[`DMS_CMD_START]
              && !cmd[`DMS_CMD_HALT])) begin
            next_run = DMS_RUN_MOVE; // [RULE14]
          end
        end
        default: next_run = DMS_RUN_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run <= DMS_RUN_IDLE;
    end else begin
      run <= next_run;
    end
  end

  // stored block selection and resume memory [RULE12]
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      active_blk   <= `DMS_BLK_FIRST;
      resume_ok    <= 1'b0;
      blk_auto_out <= 1'b0;
    end else if (run == DMS_RUN_IDLE && next_run == DMS_RUN_MOVE) begin
      active_blk   <= start_blk; // [RULE16] [RULE17]
      blk_auto_out <= cmd[`DMS_CMD_SEQ]; // [RULE13]
      resume_ok    <= 1'b0;
    end else if (run == DMS_RUN_MOVE && next_run == DMS_RUN_STOP) begin
      resume_ok    <= 1'b1;
    end else if (run == DMS_RUN_MOVE && next_run == DMS_RUN_IDLE) begin
      resume_ok    <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      blk_run_out  <= 1'b0;
      blk_stop_out <= 1'b0;
      blk_num_out  <= `DMS_BLK_FIRST;
    end else begin
      blk_run_out  <= (next_run == DMS_RUN_MOVE); // [RULE13]
      blk_stop_out <= (next_run == DMS_RUN_STOP); // [RULE14] [RULE15]
      blk_num_out  <= (run == DMS_RUN_IDLE) ? start_blk : active_blk;
    end
  end

endmodule

// >>> design/dms_consts.svh
// constants of the drive mode sequencer: offsets, fields, codes, reset values
`ifndef DMS_CONSTS_SVH
`define DMS_CONSTS_SVH

// register byte offsets
`define DMS_OFF_CMD      12'h000
`define DMS_OFF_STAT     12'h004
`define DMS_OFF_MODE     12'h008
`define DMS_OFF_VTGT     12'h00C
`define DMS_OFF_VACT     12'h010
`define DMS_OFF_BLOCK    12'h014
`define DMS_OFF_DRVSTAT  12'h018

// reset values
`define DMS_RST_CMD      16'h0000
`define DMS_RST_MODE     8'h00
`define DMS_RST_VTGT     32'h0000_0000

// mode selector codes
`define DMS_MODE_CSV     8'h09
`define DMS_MODE_TTR     8'hFF

// command word fields
`define DMS_CMD_SEQ      4
`define DMS_CMD_RESUME   6
`define DMS_CMD_HALT     8
`define DMS_CMD_START    9
`define DMS_CMD_SEL_LO   11
`define DMS_CMD_SEL_HI   15

// command low nibble codes
`define DMS_NIB_SHUT     4'h6
`define DMS_NIB_SWON     4'h7
`define DMS_NIB_ENOP     4'hF

// status word codes and fields
`define DMS_ST_DIS       16'h0050
`define DMS_ST_RDY       16'h0031
`define DMS_ST_SWON      16'h0033
`define DMS_ST_ENOP_LO   8'h37
`define DMS_ST_INPROG    8
`define DMS_ST_TREACH    10
`define DMS_ST_FOLLOW    12
`define DMS_ST_FERR      13

// drive status input fields
`define DMS_DS_BLK_DONE  0
`define DMS_DS_SEQ_END   1
`define DMS_DS_IN_WIN    2
`define DMS_DS_FERR      3
`define DMS_DS_SPEED0    4

// block numbering
`define DMS_BLK_FIRST    6'h01

`endif

// >>> design/dms_pkg.sv
// types of the drive mode sequencer
package dms_pkg;

  typedef enum logic [1:0] {
    DMS_DEV_DIS  = 2'b00,
    DMS_DEV_RDY  = 2'b01,
    DMS_DEV_SWON = 2'b10,
    DMS_DEV_ENOP = 2'b11
  } dms_dev_t;

  typedef enum logic [1:0] {
    DMS_RUN_IDLE = 2'b00,
    DMS_RUN_MOVE = 2'b01,
    DMS_RUN_STOP = 2'b10
  } dms_run_t;

endpackage

// >>> design/dms_reg_if.sv
// register side signals passed between bus slave and sequencer core
`timescale 1ns/10ps
interface dms_reg_if;
  logic        wr_stb;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_stb;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;

  modport slave (
    output wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
    input  wr_ok, rd_data, rd_ok
  );
  modport core (
    input  wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
    output wr_ok, rd_data, rd_ok
  );
endinterface

// >>> design/dms_axil_slave.sv
// axi4-lite slave front end of the drive mode sequencer
`timescale 1ns/10ps
module dms_axil_slave
  import dms_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  // write address and data
  input  wire logic [11:0] awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  // write response
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  // read
  input  wire logic [11:0] araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  // core side
  dms_reg_if.slave         regs
);

  logic        aw_full;
  logic        w_full;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // ------------------------------
  // write channel
  // ------------------------------
  assign awready_out = !aw_full && !bvalid_out;
  assign wready_out  = !w_full && !bvalid_out;
  assign regs.wr_stb  = aw_full && w_full && !bvalid_out;
  assign regs.wr_addr = aw_addr;
  assign regs.wr_data = w_data;
  assign regs.wr_strb = w_strb;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_full    <= 1'b0;
      w_full     <= 1'b0;
      aw_addr    <= 12'h000;
      w_data     <= 32'h0000_0000;
      w_strb     <= 4'h0;
      bvalid_out <= 1'b0;
      bresp_out  <= 2'h0;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_full <= 1'b1;
        aw_addr <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_full <= 1'b1;
        w_data <= wdata_in;
        w_strb <= wstrb_in;
      end
      if (regs.wr_stb) begin
        aw_full    <= 1'b0;
        w_full     <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out  <= regs.wr_ok ? 2'h0 : 2'h2;
      end else if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
      end
    end
  end

  // ------------------------------
  // read channel
  // ------------------------------
  assign arready_out  = !rvalid_out;
  assign regs.rd_stb  = arvalid_in && arready_out;
  assign regs.rd_addr = araddr_in;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rvalid_out <= 1'b0;
      rdata_out  <= 32'h0000_0000;
      rresp_out  <= 2'h0;
    end else if (regs.rd_stb) begin
      rvalid_out <= 1'b1;
      rdata_out  <= regs.rd_data;
      rresp_out  <= regs.rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
    end
  end

endmodule

// >>> design/dms_edge_sync.sv
// two-flop synchroniser for drive feedback pins
`timescale 1ns/10ps
module dms_edge_sync #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ------------------------------
  // two flip-flop crossing
  // ------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// >>> tb/dms_props.sv
// concurrent checks on the sequencer ports
`timescale 1ns/10ps
module dms_props #(
  parameter int VEL_W = 32
) (
  // clock and reset
  input wire logic             mclk_in,
  input wire logic             nrst_in,
  // register bus
  input wire logic             awvalid_in,
  input wire logic             awready_out,
  input wire logic             wvalid_in,
  input wire logic             wready_out,
  input wire logic [1:0]       bresp_out,
  input wire logic             bvalid_out,
  input wire logic             bready_in,
  input wire logic             arvalid_in,
  input wire logic             arready_out,
  input wire logic [31:0]      rdata_out,
  input wire logic             rvalid_out,
  input wire logic             rready_in,
  // motion outputs
  input wire logic [VEL_W-1:0] vel_target_out,
  input wire logic             vel_run_out,
  input wire logic             blk_run_out,
  input wire logic             blk_stop_out,
  input wire logic [5:0]       blk_num_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  property p_vtgt;
    !vel_run_out |-> vel_target_out == '0;
  endproperty
  a_vtgt: assert property (p_vtgt)
    else $error("velocity target set while idle");
  property p_excl;
    !(vel_run_out && blk_run_out);
  endproperty
  a_excl: assert property (p_excl)
    else $error("both modes running");
  property p_num;
    blk_num_out >= 6'h01 && blk_num_out <= 6'h20;
  endproperty
  a_num: assert property (p_num)
    else $error("block number out of range");
  property p_bans;
    awvalid_in && awready_out && wvalid_in && wready_out |-> ##2 bvalid_out;
  endproperty
  a_bans: assert property (p_bans)
    else $error("write response late");
  property p_bhold;
    bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_bdrop;
    bvalid_out && bready_in |=> !bvalid_out;
  endproperty
  a_bdrop: assert property (p_bdrop)
    else $error("write response repeated");
  property p_rans;
    arvalid_in && arready_out |=> rvalid_out;
  endproperty
  a_rans: assert property (p_rans)
    else $error("read answer late");
  property p_rhold;
    rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read answer dropped");
  c_vrun: cover property ($rose(vel_run_out));
  c_brun: cover property ($rose(blk_run_out));
  c_stop: cover property ($rose(blk_stop_out));
endmodule

// >>> tb/dms_plc_model.sv
// controller model: bus master and start sequences
`timescale 1ns/10ps
`include "dms_consts.svh"
module dms_plc_model (
  // clock
  input  wire logic        mclk_in,
  // write channels
  output logic [11:0]      awaddr_out,
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic [31:0]      wdata_out,
  output logic [3:0]       wstrb_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  // read channels
  output logic [11:0]      araddr_out,
  output logic             arvalid_out,
  input  wire logic        arready_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in,
  input  wire logic        rvalid_in,
  output logic             rready_out
);
  initial {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out,
           bready_out, araddr_out, arvalid_out, rready_out} = '0;

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge mclk_in);
    {awaddr_out, wdata_out, wstrb_out} <= {a, d, 4'hF};
    {awvalid_out, wvalid_out, bready_out} <= 3'b111;
    do begin
      @(posedge mclk_in);
      if (awready_in) awvalid_out <= 1'b0;
      if (wready_in) wvalid_out <= 1'b0;
    end while (!bvalid_in);
    r = bresp_in;
    bready_out <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge mclk_in);
    {araddr_out, arvalid_out, rready_out} <= {a, 2'b11};
    do begin
      @(posedge mclk_in);
      if (arready_in) arvalid_out <= 1'b0;
    end while (!rvalid_in);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask

  // mode change only from the switched-on state
  task automatic mode_set(input logic [7:0] m);
    logic [31:0] s;
    logic [1:0]  r;
    do rd(`DMS_OFF_STAT, s, r); while (s[7:0] !== 8'h33);
    wr(`DMS_OFF_MODE, {24'h0, m}, r);
  endtask

  // enabling sequence, then wait for following
  task automatic csv_on();
    logic [31:0] s;
    logic [1:0]  r;
    wr(`DMS_OFF_CMD, 32'h0, r);
    wr(`DMS_OFF_CMD, 32'h6, r);
    wr(`DMS_OFF_CMD, 32'h7, r);
    wr(`DMS_OFF_CMD, 32'hF, r);
    do rd(`DMS_OFF_STAT, s, r); while (s[12] !== 1'b1);
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench of the drive mode sequencer
`timescale 1ns/10ps
`include "dms_consts.svh"
module tb;
  typedef struct packed {
    logic [11:0] a;
    logic [15:0] d, m, s;
    logic [3:0]  o;
    logic [5:0]  n;
  } dms_row_t;
  localparam logic [11:0] C = `DMS_OFF_CMD;
  localparam logic [11:0] M = `DMS_OFF_MODE;
  // address, data, status mask, status, {vrun,brun,stop,auto}, block
  dms_row_t rows [12] = '{
    '{M, 16'h0009, 16'h0000, 16'h0000, 4'h0, 6'h01},
    '{C, 16'h0000, 16'hFFFF, 16'h0050, 4'h0, 6'h01},
    '{C, 16'h0006, 16'hFFFF, 16'h0031, 4'h0, 6'h01},
    '{C, 16'h0007, 16'hFFFF, 16'h0033, 4'h0, 6'h01},
    '{C, 16'h000F, 16'h30FF, 16'h1037, 4'h8, 6'h01},
    '{C, 16'h071F, 16'h30FF, 16'h1037, 4'h8, 6'h01},
    '{C, 16'h0007, 16'hFFFF, 16'h0033, 4'h0, 6'h01},
    '{C, 16'h000F, 16'h30FF, 16'h1037, 4'h8, 6'h01},
    '{C, 16'h0007, 16'hFFFF, 16'h0033, 4'h0, 6'h01},
    '{M, 16'h00FF, 16'h0000, 16'h0000, 4'h0, 6'h01},
    '{C, 16'h000F, 16'h00FF, 16'h0037, 4'h0, 6'h01},
    '{C, 16'h020F, 16'h01FF, 16'h0137, 4'h4, 6'h01}};
  logic        mclk_in = 1'b0;
  logic        nrst_in, awvalid_in, awready_out, wvalid_in, wready_out;
  logic        bvalid_out, bready_in, arvalid_in, arready_out;
  logic        rvalid_out, rready_in, vel_run_out, blk_run_out;
  logic        blk_stop_out, blk_auto_out;
  logic [11:0] awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out, vel_target_out, d;
  logic [4:0]  drive_fb_in;
  logic [3:0]  wstrb_in;
  logic [1:0]  bresp_out, rresp_out, r;
  logic [5:0]  blk_num_out;
  int          fails = 0;
  int          cmp_count = 0;
  always #25 mclk_in = ~mclk_in;

  dms_sequencer #(.VEL_W(32)) dut (.*);
  dms_plc_model plc (
    .mclk_in(mclk_in), .awaddr_out(awaddr_in), .awvalid_out(awvalid_in),
    .awready_in(awready_out), .wdata_out(wdata_in),
    .wstrb_out(wstrb_in), .wvalid_out(wvalid_in),
    .wready_in(wready_out), .bresp_in(bresp_out),
    .bvalid_in(bvalid_out), .bready_out(bready_in),
    .araddr_out(araddr_in), .arvalid_out(arvalid_in),
    .arready_in(arready_out), .rdata_in(rdata_out),
    .rresp_in(rresp_out), .rvalid_in(rvalid_out),
    .rready_out(rready_in));

  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic st(input logic [15:0] m, e);
    plc.rd(`DMS_OFF_STAT, d, r);
    chk({16'h0, d[15:0] & m}, {16'h0, e});
  endtask
  task automatic ob(input logic [3:0] o, input logic [5:0] n);
    chk({22'h0, vel_run_out, blk_run_out, blk_stop_out, blk_auto_out,
         blk_num_out}, {22'h0, o, n});
  endtask
  task automatic cmd(input logic [15:0] v);
    plc.wr(C, {16'h0, v}, r);
    repeat (4) @(posedge mclk_in);
  endtask
  task automatic fb(input logic [4:0] v);
    @(posedge mclk_in) drive_fb_in <= v;
    repeat (6) @(posedge mclk_in);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    fails++;
    results();
  end

  initial begin
    nrst_in = 1'b0;
    drive_fb_in = 5'h00;
    repeat (16) @(posedge mclk_in);
    nrst_in <= 1'b1;
    foreach (rows[i]) begin
      plc.wr(rows[i].a, {16'h0, rows[i].d}, r);
      repeat (4) @(posedge mclk_in);
      st(rows[i].m, rows[i].s);
      ob(rows[i].o, rows[i].n);
    end
    fb(5'h01);
    st(16'h01FF, 16'h0037);
    ob(4'h0, 6'h01);
    fb(5'h00);
    ob(4'h0, 6'h01);
    cmd(16'hF81F);
    cmd(16'hFA1F);
    ob(4'h5, 6'h20);
    fb(5'h04);
    st(16'h0500, 16'h0500);
    cmd(16'hFB1F);
    chk(blk_stop_out, 32'h1);
    st(16'h00FF, 16'h0037);
    cmd(16'hF81F);
    chk(blk_stop_out, 32'h1);
    cmd(16'h0007);
    cmd(16'h004F);
    cmd(16'h0A5F);
    chk({blk_run_out, blk_num_out}, {1'b1, 6'h20});
    fb(5'h03);
    chk(blk_run_out, 32'h0);
    fb(5'h00);
    cmd(16'h0000);
    cmd(16'h0200);
    chk(blk_run_out, 32'h0);
    st(16'hFFFF, 16'h0050);
    cmd(16'h0006);
    cmd(16'h0007);
    plc.mode_set(8'h09);
    plc.csv_on();
    // reference steps kept small by the controller
    plc.wr(`DMS_OFF_VTGT, 32'h0000_0100, r);
    repeat (4) @(posedge mclk_in);
    chk(vel_target_out, 32'h0000_0100);
    plc.wr(`DMS_OFF_VTGT, 32'h0000_0140, r);
    repeat (4) @(posedge mclk_in);
    chk(vel_target_out, 32'h0000_0140);
    fb(5'h08);
    st(16'h2000, 16'h2000);
    fb(5'h00);
    st(16'h3000, 16'h1000);
    plc.rd(12'h100, d, r);
    chk(d, 32'h0);
    chk(r, 32'h2);
    plc.wr(`DMS_OFF_STAT, 32'h0000_FFFF, r);
    chk(r, 32'h0);
    @(posedge mclk_in) nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    ob(4'h0, 6'h01);
    chk(vel_target_out, 32'h0);
    nrst_in <= 1'b1;
    st(16'hFFFF, 16'h0050);
    results();
  end
endmodule

bind dms_sequencer dms_props #(.VEL_W(VEL_W)) u_props (.*);
